// [hw/sgc_defines.vh]
// Constants for the dual serial module global control block
`ifndef SGC_DEFINES_VH
`define SGC_DEFINES_VH

// Register word indices (byte address = 2 * index)
`define SGC_IDX_CONFIG      3'h0
`define SGC_IDX_TEST        3'h1
`define SGC_IDX_LEVEL_VEC   3'h2
`define SGC_IDX_PIN_CTL     3'h3
`define SGC_IDX_PORT_DATA   3'h4

// Module configuration word fields
`define SGC_CFG_STOP        15
`define SGC_CFG_FRZ1        14
`define SGC_CFG_FRZ0        13
`define SGC_CFG_ARBITRATION_NUMBER_HI     3
`define SGC_CFG_ARBITRATION_NUMBER_LO     0

// Interrupt level word: queued level in high byte bits 5:3, async bits 2:0
`define SGC_LVL_Q_HI        13
`define SGC_LVL_Q_LO        11
`define SGC_LVL_A_HI        10
`define SGC_LVL_A_LO        8

// Reset values
`define SGC_RST_STOP        1'b1
`define SGC_RST_VECTOR      8'h0F
// Stored part of the reset vector, bits 7:1
`define SGC_RST_VEC_FIELD   7'h07
`define SGC_RST_ARBITRATION_NUMBER        4'h0
`define SGC_RST_LEVEL       3'h0
`define SGC_RST_PINREG      8'h00

// Arbitration number top bit index, sent in the first serial contention step
`define SGC_ARB_STEPS       2'h3

// Pin indices
`define SGC_PIN_MISO        0
`define SGC_PIN_MOSI        1
`define SGC_PIN_SCK         2
`define SGC_PIN_SEL0        3
`define SGC_PIN_TXD         7

`endif

// [hw/sgc_global_ctl.v]
// Global control, interrupt arbitration and pin control of the dual serial module
`timescale 1ns/1ps
`include "sgc_defines.vh"

module sgc_global_ctl (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_b,
  // Internal module bus register port
  input  wire        bus_rd,
  input  wire        bus_wr_hi,
  input  wire        bus_wr_lo,
  input  wire [2:0]  bus_word,
  input  wire [15:0] bus_wdata,
  output reg  [15:0] bus_rdata,
  // Stop and freeze
  input  wire        bus_freeze,
  input  wire        queued_boundary,
  output reg         module_clock_en,
  output reg         freeze_halt,
  // Interrupt requests and acknowledge
  input  wire        queued_irq,
  input  wire        async_irq,
  input  wire        iack_cycle,
  input  wire [2:0]  priority_mask,
  input  wire        arb_line,
  output reg         arb_drive,
  output reg  [7:1]  irq_lines,
  output reg  [7:0]  vector_out,
  output reg         vector_valid,
  // Serial engine status
  input  wire        queued_enable_bit,
  input  wire        queued_master,
  input  wire        transmitter_enable_bit,
  // Serial engine outputs toward pins
  input  wire        eng_miso_out,
  input  wire        eng_mosi_out,
  input  wire        eng_sck_out,
  input  wire [3:0]  eng_select_out,
  input  wire        eng_txd,
  // Pin inputs toward serial engine
  output reg         eng_miso_in,
  output reg         eng_mosi_in,
  output reg         eng_sck_in,
  output reg         eng_slave_select_b,
  output reg         mode_fault,
  // Port pins
  input  wire [7:0]  pin_in,
  output reg  [7:0]  pin_out,
  output reg  [7:0]  pin_oe
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ARB  = 2'h1;
  localparam [1:0] ST_VEC  = 2'h2;
  localparam [1:0] ST_WAIT = 2'h3;

  // Register state
  reg        stop;
  reg        frz1;
  reg        frz0;
  reg [3:0]  arbitration_number;
  reg [2:0]  queued_irq_level;
  reg [2:0]  async_irq_level;
  reg [7:1]  vector_number_field;
  reg [7:0]  pin_assignment;
  reg [7:0]  pin_direction;
  reg [7:0]  port_data;

  // Pin synchroniser
  reg [7:0]  pin_meta;
  reg [7:0]  pin_sync;

  // Arbitration state
  reg [1:0]  state;
  reg [1:0]  arb_step;
  reg        arb_src;

  // Combinational terms
  reg [2:0]  pend_level;
  reg        pend_src;
  reg [15:0] next_rdata;
  reg [7:0]  next_oe;
  reg [7:0]  next_out;
  reg        next_miso_in;
  reg        next_mosi_in;
  reg        next_sck_in;
  reg        next_ss_b;
  reg        next_fault;
  reg [7:1]  next_irq;

  wire wr_cfg = (bus_word == `SGC_IDX_CONFIG);
  wire wr_lvl = (bus_word == `SGC_IDX_LEVEL_VEC);
  wire wr_pin = (bus_word == `SGC_IDX_PIN_CTL);
  wire wr_prt = (bus_word == `SGC_IDX_PORT_DATA);
  wire q_req  = queued_irq & (queued_irq_level != 3'h0);
  wire a_req  = async_irq & (async_irq_level != 3'h0);
  wire my_bit = arbitration_number[arb_step];

  // Register writes; only implemented bits are stored
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stop                <= `SGC_RST_STOP;
      frz1                <= 1'b0;
      frz0                <= 1'b0;
      arbitration_number  <= `SGC_RST_ARBITRATION_NUMBER;
      queued_irq_level    <= `SGC_RST_LEVEL;
      async_irq_level     <= `SGC_RST_LEVEL;
      vector_number_field <= `SGC_RST_VEC_FIELD;
      pin_assignment      <= `SGC_RST_PINREG;
      pin_direction       <= `SGC_RST_PINREG;
      port_data           <= `SGC_RST_PINREG;
    end else begin
      // Writes are honoured in stop as well
      if (bus_wr_hi && wr_cfg) begin
        stop <= bus_wdata[`SGC_CFG_STOP];
        frz1 <= bus_wdata[`SGC_CFG_FRZ1];
        frz0 <= bus_wdata[`SGC_CFG_FRZ0];
      end
      if (bus_wr_lo && wr_cfg) begin
        arbitration_number <= bus_wdata[`SGC_CFG_ARBITRATION_NUMBER_HI:`SGC_CFG_ARBITRATION_NUMBER_LO];
      end
      if (bus_wr_hi && wr_lvl) begin
        queued_irq_level <= bus_wdata[`SGC_LVL_Q_HI:`SGC_LVL_Q_LO];
        async_irq_level  <= bus_wdata[`SGC_LVL_A_HI:`SGC_LVL_A_LO];
      end
      if (bus_wr_lo && wr_lvl) begin
        vector_number_field <= bus_wdata[7:1];
      end
      if (bus_wr_hi && wr_pin) begin
        pin_assignment <= bus_wdata[15:8];
      end
      if (bus_wr_lo && wr_pin) begin
        pin_direction <= bus_wdata[7:0];
      end
      if (bus_wr_lo && wr_prt) begin
        port_data <= bus_wdata[7:0];
      end
    end
  end

  // Read mux
  always @* begin
    next_rdata = 16'h0000;
    case (bus_word)
      `SGC_IDX_CONFIG: begin
        next_rdata[`SGC_CFG_STOP]                    = stop;
        next_rdata[`SGC_CFG_FRZ1]                    = frz1;
        next_rdata[`SGC_CFG_FRZ0]                    = frz0;
        next_rdata[`SGC_CFG_ARBITRATION_NUMBER_HI:`SGC_CFG_ARBITRATION_NUMBER_LO] = arbitration_number;
      end
      `SGC_IDX_LEVEL_VEC: begin
        next_rdata[`SGC_LVL_Q_HI:`SGC_LVL_Q_LO] = queued_irq_level;
        next_rdata[`SGC_LVL_A_HI:`SGC_LVL_A_LO] = async_irq_level;
        next_rdata[7:0] = {vector_number_field, 1'b1};
      end
      `SGC_IDX_PIN_CTL: begin
        next_rdata = {pin_assignment, pin_direction};
      end
      `SGC_IDX_PORT_DATA: begin
        next_rdata[7:0] = pin_sync;
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
    if (stop && (bus_word != `SGC_IDX_CONFIG)) begin
      next_rdata = 16'h0000;
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus_rdata <= 16'h0000;
    end else if (bus_rd) begin
      bus_rdata <= next_rdata;
    end
  end

  // Stop gating and freeze halt
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      module_clock_en <= 1'b0;
      freeze_halt     <= 1'b0;
    end else begin
      module_clock_en <= ~stop;
      if (!bus_freeze || !frz1) begin
        freeze_halt <= 1'b0;
      end else if (queued_boundary) begin
        freeze_halt <= 1'b1;
      end
    end
  end

  // Pending request and level line select
  always @* begin
    if (q_req) begin
      pend_level = queued_irq_level;
      pend_src   = 1'b1;
    end else if (a_req) begin
      pend_level = async_irq_level;
      pend_src   = 1'b0;
    end else begin
      pend_level = 3'h0;
      pend_src   = 1'b0;
    end
    next_irq = 7'h00;
    if (pend_level != 3'h0 && arbitration_number != 4'h0) begin
      next_irq[pend_level] = 1'b1;
    end
  end

  // Acknowledge: serial contention then vector drive
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state        <= ST_IDLE;
      arb_step     <= 2'h0;
      arb_src      <= 1'b0;
      arb_drive    <= 1'b0;
      irq_lines    <= 7'h00;
      vector_out   <= 8'h00;
      vector_valid <= 1'b0;
    end else begin
      irq_lines <= next_irq;
      case (state)
        ST_IDLE: begin
          arb_drive    <= 1'b0;
          vector_valid <= 1'b0;
          if (iack_cycle && arbitration_number != 4'h0 &&
              pend_level > priority_mask) begin
            state     <= ST_ARB;
            arb_step  <= `SGC_ARB_STEPS;
            arb_src   <= pend_src;
            arb_drive <= arbitration_number[`SGC_ARB_STEPS];
          end else if (iack_cycle) begin
            state <= ST_WAIT;
          end
        end
        ST_ARB: begin
          if (!iack_cycle) begin
            state     <= ST_IDLE;
            arb_drive <= 1'b0;
          end else if (!my_bit && arb_line) begin
            state     <= ST_WAIT;
            arb_drive <= 1'b0;
          end else if (arb_step == 2'h0) begin
            state     <= ST_VEC;
            arb_drive <= 1'b0;
          end else begin
            arb_step  <= arb_step - 2'h1;
            arb_drive <= arbitration_number[arb_step - 2'h1];
          end
        end
        ST_VEC: begin
          // Acknowledge withdrawn before the vector: no vector shown
          vector_out   <= {vector_number_field, arb_src};
          vector_valid <= iack_cycle;
          state        <= iack_cycle ? ST_WAIT : ST_IDLE;
        end
        ST_WAIT: begin
          arb_drive <= 1'b0;
          if (!iack_cycle) begin
            state        <= ST_IDLE;
            vector_valid <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Pin input synchroniser
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // Pin function mux
  always @* begin
    next_oe      = pin_direction;
    next_out     = port_data;
    next_miso_in = 1'b0;
    next_mosi_in = 1'b0;
    next_sck_in  = 1'b0;
    next_ss_b    = 1'b1;
    next_fault   = 1'b0;
    if (pin_assignment[`SGC_PIN_MISO]) begin
      next_out[`SGC_PIN_MISO] = eng_miso_out;
      if (queued_master) begin
        next_oe[`SGC_PIN_MISO] = 1'b0;
        next_miso_in = ~pin_direction[`SGC_PIN_MISO] & pin_sync[`SGC_PIN_MISO];
      end
    end
    if (pin_assignment[`SGC_PIN_MOSI]) begin
      next_out[`SGC_PIN_MOSI] = eng_mosi_out;
      if (!queued_master) begin
        next_oe[`SGC_PIN_MOSI] = 1'b0;
        next_mosi_in = ~pin_direction[`SGC_PIN_MOSI] & pin_sync[`SGC_PIN_MOSI];
      end
    end
    if (pin_assignment[`SGC_PIN_SCK] && queued_enable_bit) begin
      next_out[`SGC_PIN_SCK] = eng_sck_out;
      next_oe[`SGC_PIN_SCK]  = queued_master;
      next_sck_in = ~queued_master & pin_sync[`SGC_PIN_SCK];
    end
    if (pin_assignment[`SGC_PIN_SEL0]) begin
      next_out[`SGC_PIN_SEL0] = eng_select_out[0];
      if (queued_master) begin
        next_fault = ~pin_direction[`SGC_PIN_SEL0] & ~pin_sync[`SGC_PIN_SEL0];
      end else begin
        next_oe[`SGC_PIN_SEL0] = 1'b0;
        next_ss_b = pin_direction[`SGC_PIN_SEL0] | pin_sync[`SGC_PIN_SEL0];
      end
    end
    if (pin_assignment[4]) begin
      next_out[4] = eng_select_out[1];
      next_oe[4]  = queued_master & pin_direction[4];
    end
    if (pin_assignment[5]) begin
      next_out[5] = eng_select_out[2];
      next_oe[5]  = queued_master & pin_direction[5];
    end
    if (pin_assignment[6]) begin
      next_out[6] = eng_select_out[3];
      next_oe[6]  = queued_master & pin_direction[6];
    end
    if (transmitter_enable_bit) begin
      next_out[`SGC_PIN_TXD] = eng_txd;
      next_oe[`SGC_PIN_TXD]  = 1'b1;
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_out            <= 8'h00;
      pin_oe             <= 8'h00;
      eng_miso_in        <= 1'b0;
      eng_mosi_in        <= 1'b0;
      eng_sck_in         <= 1'b0;
      eng_slave_select_b <= 1'b1;
      mode_fault         <= 1'b0;
    end else begin
      pin_out            <= next_out;
      pin_oe             <= next_oe;
      eng_miso_in        <= next_miso_in;
      eng_mosi_in        <= next_mosi_in;
      eng_sck_in         <= next_sck_in;
      eng_slave_select_b <= next_ss_b;
      mode_fault         <= next_fault;
    end
  end

endmodule

// [bench/sgc_global_ctl_props.sv]
// Checker for the dual serial module global control block
`timescale 1ns/1ps
module sgc_global_ctl_props (
  // Clock and reset
  input wire        clock,
  input wire        rst_b,
  // Register bus
  input wire        bus_rd,
  input wire        bus_wr_hi,
  input wire        bus_wr_lo,
  input wire [2:0]  bus_word,
  input wire [15:0] bus_wdata,
  input wire [15:0] bus_rdata,
  // Stop and freeze
  input wire        bus_freeze,
  input wire        queued_boundary,
  input wire        module_clock_en,
  input wire        freeze_halt,
  // Interrupts
  input wire        iack_cycle,
  input wire [2:0]  priority_mask,
  input wire        arb_drive,
  input wire [7:1]  irq_lines,
  input wire [7:0]  vector_out,
  input wire        vector_valid,
  // Transmit pin
  input wire        transmitter_enable_bit,
  input wire        eng_txd,
  input wire [7:0]  pin_out,
  input wire [7:0]  pin_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  reg       stop_m;
  reg       frz1_m;
  reg [3:0] arb_m;
  reg [7:1] vec_m;
  wire      contend;
  // Shadow of the fields the assertions depend on
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stop_m <= 1'b1;
      frz1_m <= 1'b0;
      arb_m  <= 4'h0;
      vec_m  <= 7'h07;
    end else begin
      if (bus_wr_hi && bus_word == 3'h0) begin
        stop_m <= bus_wdata[15];
        frz1_m <= bus_wdata[14];
      end
      if (bus_wr_lo && bus_word == 3'h0)
        arb_m <= bus_wdata[3:0];
      if (bus_wr_lo && bus_word == 3'h2)
        vec_m <= bus_wdata[7:1];
    end
  end
  // One-hot line L outranks mask m exactly when its value reaches 1 << m
  assign contend = (arb_m != 4'h0) && ({1'b0, irq_lines} >= (8'h01 << priority_mask));
  sequence arb_steps;
    arb_drive == arb_m[3] ##1 arb_drive == arb_m[2] ##1 arb_drive == arb_m[1]
      ##1 arb_drive == arb_m[0];
  endsequence
  sequence no_drive;
    !arb_drive [*4];
  endsequence
  unimpl_zero_a:
    assert property (bus_rd && (bus_word == 3'h1 || bus_word > 3'h4) |=> bus_rdata == 16'h0000)
      else $error("unmapped word read nonzero");
  stop_read_a:
    assert property (bus_rd && bus_word != 3'h0 && stop_m |=> bus_rdata == 16'h0000)
      else $error("read during stop not zero");
  clk_gate_a:
    assert property (module_clock_en != $past(stop_m)) else $error("clock enable wrong");
  vec_bit0_a:
    assert property (bus_rd && bus_word == 3'h2 && !stop_m |=> bus_rdata[0])
      else $error("vector bit 0 not one");
  freeze_set_a:
    assert property (queued_boundary && bus_freeze && frz1_m |=> freeze_halt)
      else $error("no halt at boundary");
  freeze_clr_a:
    assert property (!frz1_m || !bus_freeze |=> !freeze_halt) else $error("halt without freeze");
  arb_zero_a:
    assert property (arb_m == 4'h0 && !stop_m |=> irq_lines == 7'h00)
      else $error("request with zero arbitration number");
  arb_serial_a:
    assert property ($rose(iack_cycle) && contend |=> arb_steps) else $error("bad contention");
  no_contend_a:
    assert property ($rose(iack_cycle) && !contend |=> no_drive) else $error("contended");
  vec_out_a:
    assert property (vector_valid |-> vector_out[7:1] == vec_m) else $error("vector bits wrong");
  vec_drop_a:
    assert property (!iack_cycle |=> !vector_valid && !arb_drive) else $error("vector held");
  txd_force_a:
    assert property (transmitter_enable_bit && !stop_m |=> pin_oe[7] && pin_out[7] == $past(eng_txd))
      else $error("transmit pin not forced");
endmodule
bind sgc_global_ctl sgc_global_ctl_props chk (.*);

// [bench/sgc_cpu_model.sv]
// Processor core model: register cycles and interrupt acknowledge
`timescale 1ns/1ps
module sgc_cpu_model (
  // Clock
  input  wire        clock,
  // Register bus
  output reg         bus_rd,
  output reg         bus_wr_hi,
  output reg         bus_wr_lo,
  output reg  [2:0]  bus_word,
  output reg  [15:0] bus_wdata,
  input  wire [15:0] bus_rdata,
  // Acknowledge and arbitration
  output reg         iack_cycle,
  output reg  [2:0]  priority_mask,
  output wire        arb_line,
  input  wire        arb_drive,
  input  wire [7:0]  vector_out,
  input  wire        vector_valid
);
  reg other_bit;
  assign arb_line = arb_drive | other_bit;
  initial begin
    {bus_rd, bus_wr_hi, bus_wr_lo, iack_cycle, other_bit} = 5'h00;
    bus_word = 3'h0;
    bus_wdata = 16'h0000;
    priority_mask = 3'h0;
  end
  task wr(input [2:0] w, input [15:0] d);
    begin
      @(posedge clock) #1;
      bus_word = w;
      bus_wdata = d;
      {bus_wr_hi, bus_wr_lo} = 2'h3;
      @(posedge clock) #1;
      {bus_wr_hi, bus_wr_lo} = 2'h0;
      bus_wdata = ~d;
    end
  endtask
  task rd(input [2:0] w, output [15:0] d);
    begin
      @(posedge clock) #1;
      bus_word = w;
      bus_rd = 1'b1;
      @(posedge clock) #1;
      bus_rd = 1'b0;
      d = bus_rdata;
    end
  endtask
  // Competitor oth contends serially, MSB first, beside the block
  task iack(input [2:0] m, input [3:0] oth, output [7:0] v);
    integer i;
    begin
      v = 8'h00;
      @(posedge clock) #1;
      priority_mask = m;
      iack_cycle = 1'b1;
      for (i = 3; i >= 0; i = i - 1) begin
        @(posedge clock) #1;
        other_bit = oth[i];
      end
      @(posedge clock) #1;
      other_bit = 1'b0;
      for (i = 0; i < 6; i = i + 1) begin
        @(posedge clock) #1;
        if (vector_valid === 1'b1) v = vector_out;
      end
      iack_cycle = 1'b0;
      @(posedge clock) #1;
    end
  endtask
endmodule

// [bench/sgc_global_ctl_tb.sv]
// Testbench for the dual serial module global control block
`timescale 1ns/1ps
module sgc_global_ctl_tb;
  reg         clock;
  reg         rst_b, bus_freeze, queued_boundary, queued_irq, async_irq;
  reg         queued_enable_bit, queued_master, transmitter_enable_bit, eng_txd;
  reg         eng_miso_out, eng_mosi_out, eng_sck_out;
  reg  [3:0]  eng_select_out;
  reg  [7:0]  pin_in;
  wire        bus_rd, bus_wr_hi, bus_wr_lo, iack_cycle, arb_line;
  wire        module_clock_en, freeze_halt, arb_drive, vector_valid;
  wire [2:0]  bus_word, priority_mask;
  wire [15:0] bus_wdata, bus_rdata;
  wire [7:1]  irq_lines;
  wire [7:0]  vector_out, pin_out, pin_oe;
  wire        eng_miso_in, eng_mosi_in, eng_sck_in, eng_slave_select_b, mode_fault;
  integer     i, n_tests, bad_count;
  reg  [15:0] d;
  reg  [7:0]  v;
  // Word, write data, expected read back
  localparam logic [34:0] row_tab [0:5] = '{
    {3'h0, 16'h6FF8, 16'h6008}, {3'h1, 16'hFFFF, 16'h0000},
    {3'h2, 16'hFFFF, 16'h3FFF}, {3'h2, 16'h2D40, 16'h2D41},
    {3'h5, 16'hFFFF, 16'h0000}, {3'h7, 16'hFFFF, 16'h0000}};
  sgc_global_ctl uut (.*);
  sgc_cpu_model cpu (.*);
  task check(input [15:0] seen, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    #200000;
    bad_count = bad_count + 1;
    report_and_stop;
  end
  initial begin
    n_tests = 0;
    bad_count = 0;
    {rst_b, bus_freeze, queued_boundary, queued_irq, async_irq, queued_enable_bit} = 6'h00;
    {queued_master, transmitter_enable_bit, eng_txd, eng_miso_out} = 4'h0;
    {eng_mosi_out, eng_sck_out} = 2'h0;
    eng_select_out = 4'hF;
    pin_in = 8'h00;
    repeat (16) @(posedge clock);
    #1 rst_b = 1'b1;
    check(module_clock_en, 16'h0000);
    cpu.rd(3'h0, d); check(d, 16'h8000);
    cpu.rd(3'h2, d); check(d, 16'h0000);
    cpu.wr(3'h3, 16'h00F0);
    cpu.wr(3'h0, 16'h0000);
    @(posedge clock) #1;
    check(module_clock_en, 16'h0001);
    cpu.rd(3'h2, d); check(d, 16'h000F);
    cpu.rd(3'h3, d); check(d, 16'h00F0);
    for (i = 0; i < 6; i = i + 1) begin
      cpu.wr(row_tab[i][34:32], row_tab[i][31:16]);
      cpu.rd(row_tab[i][34:32], d); check(d, row_tab[i][15:0]);
    end
    {queued_irq, async_irq} = 2'h3;
    repeat (2) @(posedge clock) #1;
    check(irq_lines, 16'h0010);
    cpu.iack(3'h4, 4'h0, v); check(v, 16'h0041);
    queued_irq = 1'b0;
    cpu.iack(3'h4, 4'h0, v); check(v, 16'h0040);
    cpu.iack(3'h5, 4'h0, v); check(v, 16'h0000);
    cpu.iack(3'h1, 4'hC, v); check(v, 16'h0000);
    for (i = 1; i < 8; i = i + 1) begin
      cpu.wr(3'h2, {5'h00, i[2:0], 8'h40});
      @(posedge clock) #1;
      check(irq_lines, 16'h0001 << (i - 1));
    end
    cpu.wr(3'h2, 16'h3840);
    @(posedge clock) #1;
    check(irq_lines, 16'h0000);
    queued_irq = 1'b1;
    cpu.wr(3'h0, 16'h0000);
    @(posedge clock) #1;
    check(irq_lines, 16'h0000);
    bus_freeze = 1'b1;
    for (i = 0; i < 2; i = i + 1) begin
      cpu.wr(3'h0, (i == 0) ? 16'h4008 : 16'h2008);
      queued_boundary = 1'b1;
      @(posedge clock) #1;
      queued_boundary = 1'b0;
      check(freeze_halt, (i == 0) ? 16'h0001 : 16'h0000);
    end
    bus_freeze = 1'b0;
    // Data latch first so no undefined level is driven
    cpu.wr(3'h4, 16'h005A);
    pin_in = 8'h3C;
    cpu.wr(3'h3, 16'h00FF);
    @(posedge clock) #1;
    check({pin_oe, pin_out}, 16'hFF5A);
    cpu.rd(3'h4, d); check(d, 16'h003C);
    {transmitter_enable_bit, eng_txd} = 2'h3;
    cpu.wr(3'h3, 16'h0000);
    @(posedge clock) #1;
    check({pin_oe, pin_out[7]}, {8'h80, 1'b1});
    {queued_enable_bit, queued_master} = 2'h3;
    cpu.wr(3'h3, 16'h7F7A);
    @(posedge clock) #1;
    check(pin_oe[6:0], 16'h007E);
    pin_in = 8'h37;
    cpu.wr(3'h3, 16'h7F70);
    @(posedge clock) #1;
    check({eng_miso_in, mode_fault}, 16'h0003);
    queued_master = 1'b0;
    @(posedge clock) #1;
    check(pin_oe[6:0], 16'h0000);
    check({eng_slave_select_b, eng_mosi_in, eng_sck_in}, 16'h0003);
    // Queued side idled before stop; writes must still land in stop
    {queued_enable_bit, queued_master} = 2'h0;
    cpu.wr(3'h0, 16'h8008);
    @(posedge clock) #1;
    check(module_clock_en, 16'h0000);
    cpu.wr(3'h2, 16'h0054);
    cpu.rd(3'h0, d); check(d, 16'h8008);
    cpu.rd(3'h2, d); check(d, 16'h0000);
    cpu.wr(3'h0, 16'h0008);
    cpu.rd(3'h2, d); check(d, 16'h0055);
    // Reset again in mid-run
    rst_b = 1'b0;
    repeat (2) @(posedge clock) #1;
    rst_b = 1'b1;
    check(module_clock_en, 16'h0000);
    cpu.rd(3'h0, d); check(d, 16'h8000);
    report_and_stop;
  end
endmodule
